// ### code_bank_mapper.sv
// Purpose: banked program flash mapper with its bank-select register
// Assumes: core presents fetch and constant accesses as single-cycle strobes
// Notes: flash address outputs are registered, one cycle after the strobe
// Notes on behaviour
// - common bank fixed at lower half
// - upper half shows one selected bank
// - fetch bank field bits 1:0 steers fetches
// - constant bank field bits 5:4 steers constants
// - fetch bank written only from bank 0
// - reserved bits read zero, write zero
// - top kilobyte of bank 3 reserved
// - register at 0xf5 on every page
// - flash is 32 kB banks, four or three
`timescale 1ns/1ps
`default_nettype none
module code_bank_mapper #(
  parameter int num_banks = 4
)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // special register port, page-independent
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [15:0] exec_pc_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // instruction fetch path
  input wire logic fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  output logic fetch_valid_o,
  output logic [16:0] fetch_flash_addr_o,
  output logic fetch_reserved_o,
  // constant read and flash write path
  input wire logic const_req_i,
  input wire logic const_write_i,
  input wire logic [15:0] const_addr_i,
  output logic const_valid_o,
  output logic const_write_o,
  output logic [16:0] const_flash_addr_o,
  output logic const_reserved_o,
  output logic bank_fault_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every register of the block except the reset synchroniser rst_sync lives in this one struct
  typedef struct packed {
    logic [1:0] fetch_bank_field;
    logic [1:0] constant_bank_field;
    logic [7:0] rdata;
    logic fetch_valid;
    logic [16:0] fetch_flash_addr;
    logic fetch_reserved;
    logic const_valid;
    logic const_write;
    logic [16:0] const_flash_addr;
    logic const_reserved;
    logic bank_fault;
  } state_type;

  localparam state_type reset_state = '{
    fetch_bank_field: code_bank_pkg::program_bank_select_reset[1:0],
    constant_bank_field: code_bank_pkg::program_bank_select_reset[5:4],
    rdata: 8'h00,
    fetch_valid: 1'b0,
    fetch_flash_addr: 17'h00000,
    fetch_reserved: 1'b0,
    const_valid: 1'b0,
    const_write: 1'b0,
    const_flash_addr: 17'h00000,
    const_reserved: 1'b0,
    bank_fault: 1'b0
  };

  state_type state;
  state_type next_state;
  logic [1:0] rst_sync;
  logic rst_n;
  logic sel_hit;
  logic [7:0] select_view;
  logic [16:0] fetch_flash;
  logic [16:0] const_flash;
  logic fetch_res;
  logic const_res;
  logic fetch_missing;
  logic const_missing;
  logic wr_hit;
  logic rd_hit;
  logic fetch_field_open;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pulls one two-bit bank field out of a register byte
  function automatic logic [1:0] bank_field(input logic [7:0] value, input int lsb);
    return value[lsb +: 2];
  endfunction

  // the byte the core reads back: fields in place, reserved bits zero
  function automatic logic [7:0] register_view(input logic [1:0] constant,
    input logic [1:0] fetch);
    return {2'h0, constant, 2'h0, fetch};
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // release is delayed two edges so every flop leaves reset on one clean edge
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // address forming
  // ----------------------------------------------------------------
  // both paths use the same former module so reserved and missing-bank tests always agree
  bank_address_former #(.num_banks(num_banks)) fetch_former (
    .code_addr_i(fetch_addr_i),
    .bank_i(state.fetch_bank_field),
    .flash_addr_o(fetch_flash),
    .reserved_o(fetch_res),
    .missing_bank_o(fetch_missing)
  );

  bank_address_former #(.num_banks(num_banks)) const_former (
    .code_addr_i(const_addr_i),
    .bank_i(state.constant_bank_field),
    .flash_addr_o(const_flash),
    .reserved_o(const_res),
    .missing_bank_o(const_missing)
  );

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // decode ignores any page select, so the register is reachable on all pages
  assign sel_hit = (reg_addr_i == code_bank_pkg::program_bank_select_addr);
  assign wr_hit = sel_hit && reg_wr_i;
  assign rd_hit = sel_hit && reg_rd_i;
  // reserved bits are not stored and always read back as zero
  assign select_view = register_view(state.constant_bank_field, state.fetch_bank_field);
  // code above 0x8000 still runs from bank 0 while the fetch field is zero,
  // so only an upper pc together with a fetch field of 1 to 3 locks the field
  assign fetch_field_open = !exec_pc_i[15]
    || (state.fetch_bank_field == code_bank_pkg::common_bank);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;

    // register writes; the fetch field may be locked by the running code
    if (wr_hit)
    begin
      next_state.constant_bank_field =
        bank_field(reg_wdata_i, code_bank_pkg::constant_bank_lsb);
      // a switch from an upper bank would pull the code out from under itself
      if (fetch_field_open)
        next_state.fetch_bank_field =
          bank_field(reg_wdata_i, code_bank_pkg::fetch_bank_lsb);
    end

    // a read copies the register view into the held read data
    if (rd_hit)
      next_state.rdata = select_view & code_bank_pkg::writable_mask;

    // access strobes and their captured addresses
    next_state.fetch_valid = fetch_req_i;
    next_state.const_valid = const_req_i;
    next_state.const_write = const_req_i && const_write_i;
    if (fetch_req_i)
    begin
      next_state.fetch_flash_addr = fetch_flash;
      next_state.fetch_reserved = fetch_res;
    end
    if (const_req_i)
    begin
      next_state.const_flash_addr = const_flash;
      next_state.const_reserved = const_res;
    end

    // a three-bank part has no bank 3; flag rather than alias into it
    next_state.bank_fault = (fetch_req_i && fetch_missing)
      || (const_req_i && const_missing);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= reset_state;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // addresses and reserved flags hold between requests; the valids, const write and bank fault pulse
  assign reg_hit_o = wr_hit || rd_hit;
  assign reg_rdata_o = state.rdata;
  assign fetch_valid_o = state.fetch_valid;
  assign fetch_flash_addr_o = state.fetch_flash_addr;
  assign fetch_reserved_o = state.fetch_reserved;
  assign const_valid_o = state.const_valid;
  assign const_write_o = state.const_write;
  assign const_flash_addr_o = state.const_flash_addr;
  assign const_reserved_o = state.const_reserved;
  assign bank_fault_o = state.bank_fault;

endmodule
`default_nettype wire

// ### code_bank_pkg.sv
// Purpose: shared constants and types for the code bank mapper
// Assumes: 8-bit special register bus, 16-bit code addresses, 17-bit flash addresses
// Notes: all offsets, field positions and reset values live here
package code_bank_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] program_bank_select_addr = 8'hf5;
  localparam logic [7:0] program_bank_select_reset = 8'h11;
  localparam int fetch_bank_lsb = 0;
  localparam int constant_bank_lsb = 4;
  localparam logic [7:0] writable_mask = 8'h33;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam int code_addr_width = 16;
  localparam int bank_offset_width = 15;
  localparam int flash_addr_width = 17;
  localparam logic [15:0] reserved_window_base = 16'hfc00;
  localparam logic [1:0] common_bank = 2'h0;
  localparam logic [1:0] top_bank = 2'h3;

  typedef enum logic [1:0] {
    access_fetch,
    access_constant_read,
    access_flash_write
  } access_kind_type;

endpackage

// ### bank_address_former.sv
// Purpose: turns a 16-bit code address and a bank number into a flash address
// Assumes: purely combinational, used once per access path
// Notes: flags the reserved top kilobyte of the last bank on four-bank parts
`timescale 1ns/1ps
`default_nettype none
module bank_address_former #(
  parameter int num_banks = 4
)
(
  input wire logic [15:0] code_addr_i,
  input wire logic [1:0] bank_i,
  output logic [16:0] flash_addr_o,
  output logic reserved_o,
  output logic missing_bank_o
);

  logic [1:0] used_bank;

  always_comb
  begin
    // lower half always comes from the common bank
    used_bank = code_addr_i[15] ? bank_i : code_bank_pkg::common_bank;
    flash_addr_o = {used_bank, code_addr_i[14:0]};
    reserved_o = (num_banks == 4) && code_addr_i[15]
      && (used_bank == code_bank_pkg::top_bank)
      && (code_addr_i >= code_bank_pkg::reserved_window_base);
    missing_bank_o = (32'(used_bank) >= num_banks);
  end

endmodule
`default_nettype wire

// ### code_bank_mapper_assertions.sv
// Purpose: port-level checks on the code bank mapper
// Assumes: one clock, no request before the internal reset is released
// Notes: the bank choice itself is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module code_bank_mapper_assertions #(
  parameter int num_banks = 4
)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [15:0] exec_pc_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic fetch_valid_o,
  input wire logic [16:0] fetch_flash_addr_o,
  input wire logic fetch_reserved_o,
  input wire logic const_req_i,
  input wire logic const_write_i,
  input wire logic const_valid_o,
  input wire logic const_write_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence bank0_wr_s;
    reg_wr_i && reg_hit_o && !exec_pc_i[15];
  endsequence
  sequence page_rd_s;
    reg_rd_i && reg_hit_o && !reg_wr_i;
  endsequence
  fetch_lat_a: assert property (fetch_req_i |=> fetch_valid_o)
    else $error("fetch valid missing");
  fetch_low_a: assert property (fetch_req_i && !fetch_addr_i[15] |=>
    fetch_flash_addr_o == {2'h0, $past(fetch_addr_i[14:0])}) else $error("lower half bank");
  fetch_off_a: assert property (fetch_req_i |=>
    fetch_flash_addr_o[14:0] == $past(fetch_addr_i[14:0])) else $error("offset bits");
  low_rsv_a: assert property (fetch_req_i && (fetch_addr_i < 16'hfc00 || num_banks != 4)
    |=> !fetch_reserved_o) else $error("reserved flag");
  const_lat_a: assert property (const_req_i |=>
    const_valid_o && const_write_o == $past(const_write_i)) else $error("const strobe");
  rsvd_zero_a: assert property (page_rd_s |=> (reg_rdata_o & 8'hcc) == 8'h00)
    else $error("reserved bits set");
  hit_dec_a: assert property (reg_hit_o == ((reg_wr_i || reg_rd_i) && reg_addr_i == 8'hf5))
    else $error("register decode");
  fetch_wr_a: assert property (bank0_wr_s ##1 page_rd_s |=>
    reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 2)) else $error("fetch field write");
endmodule
bind code_bank_mapper code_bank_mapper_assertions #(.num_banks(num_banks)) chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .exec_pc_i(exec_pc_i),
  .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .fetch_req_i(fetch_req_i),
  .fetch_addr_i(fetch_addr_i), .fetch_valid_o(fetch_valid_o),
  .fetch_flash_addr_o(fetch_flash_addr_o), .fetch_reserved_o(fetch_reserved_o),
  .const_req_i(const_req_i), .const_write_i(const_write_i),
  .const_valid_o(const_valid_o), .const_write_o(const_write_o));
`default_nettype wire

// ### core_model.sv
// Purpose: core side issuing fetch and constant strobes
// Assumes: strobes driven 1 ns after the rising edge, one cycle long
// Notes: address lines show the inverse between strobes, never a held value
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  input wire logic clk_i,
  output logic fetch_req_o = 1'b0,
  output logic [15:0] fetch_addr_o = 16'h0000,
  output logic const_req_o = 1'b0,
  output logic const_write_o = 1'b0,
  output logic [15:0] const_addr_o = 16'h0000
);
  task automatic access(input logic [15:0] fa, input logic [15:0] ca, input logic w);
    @(posedge clk_i);
    #1;
    fetch_req_o = 1'b1;
    fetch_addr_o = fa;
    const_req_o = 1'b1;
    const_write_o = w;
    const_addr_o = ca;
    @(posedge clk_i);
    #1;
    fetch_req_o = 1'b0;
    const_req_o = 1'b0;
    const_write_o = 1'b0;
    fetch_addr_o = ~fa;
    const_addr_o = ~ca;
  endtask
endmodule
`default_nettype wire

// ### code_bank_mapper_tb_top.sv
// Purpose: self-checking bench for the code bank mapper
// Assumes: four-bank part, core strobes come from core_model
// Notes: expectations are built from bank and offset fields
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module code_bank_mapper_tb_top;
  logic clk, nrst, reg_wr, reg_rd, reg_hit, f_req, f_valid, f_rsv, c_req, c_wr;
  logic c_valid, c_wr_o, c_rsv, fault;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic [15:0] exec_pc, f_addr, c_addr;
  logic [16:0] f_flash, c_flash;
  int err_count = 0;
  int cmp_count = 0;
  code_bank_mapper #(.num_banks(4)) DUT (.sys_clk_i(clk), .nrst_i(nrst),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .exec_pc_i(exec_pc), .reg_rdata_o(reg_rdata), .reg_hit_o(reg_hit), .fetch_req_i(f_req),
    .fetch_addr_i(f_addr), .fetch_valid_o(f_valid), .fetch_flash_addr_o(f_flash),
    .fetch_reserved_o(f_rsv), .const_req_i(c_req), .const_write_i(c_wr),
    .const_addr_i(c_addr), .const_valid_o(c_valid), .const_write_o(c_wr_o),
    .const_flash_addr_o(c_flash), .const_reserved_o(c_rsv), .bank_fault_o(fault));
  core_model core (.clk_i(clk), .fetch_req_o(f_req), .fetch_addr_o(f_addr),
    .const_req_o(c_req), .const_write_o(c_wr), .const_addr_o(c_addr));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // write then read back to back, so the read shows the write at once
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [15:0] pc,
    input logic w);
    step();
    reg_addr = a;
    reg_wdata = d;
    exec_pc = pc;
    reg_wr = w;
    step();
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reg;
    acc(8'hf5, 8'h00, 16'h0000, 1'b0);
    `CHK("reset value", code_bank_pkg::program_bank_select_reset, q)
    acc(8'hf5, 8'hff, 16'h0100, 1'b1);
    `CHK("masked write", code_bank_pkg::writable_mask, q)
    acc(8'hf5, 8'h00, 16'h8000, 1'b1);
    `CHK("upper pc write", 8'h03, q)
    acc(8'hf4, 8'h22, 16'h0100, 1'b1);
    `CHK("unmapped addr", 8'h03, q)
    acc(8'hf5, 8'h00, 16'h0100, 1'b0);
    `CHK("unmapped no write", 8'h03, q)
    acc(8'hf5, 8'h00, 16'h0100, 1'b1);
    `CHK("fetch clear", 8'h00, q)
    acc(8'hf5, 8'h11, 16'h8000, 1'b1);
    `CHK("upper pc bank 0", 8'h11, q)
    $display("t_reg done");
  endtask
  task automatic t_map;
    logic [1:0] b;
    for (int i = 0; i < 4; i++)
    begin
      b = i[1:0];
      acc(8'hf5, {2'h0, ~b, 2'h0, b}, 16'h0100, 1'b1); // four-bank part only
      core.access(16'h8123, 16'hc001, b[0]);
      `CHK("fetch upper", {b, 15'h0123}, f_flash)
      `CHK("const upper", {~b, 15'h4001}, c_flash)
      `CHK("const write", b[0], c_wr_o)
      `CHK("bank fault", 1'b0, fault)
      `CHK("fetch valid", 1'b1, f_valid)
      `CHK("const valid", 1'b1, c_valid)
      core.access(16'hfc00, 16'h1234, 1'b0);
      `CHK("fetch reserved", b == 2'h3, f_rsv)
      `CHK("const lower", {2'h0, 15'h1234}, c_flash)
      core.access(16'h7fff, 16'hfffe, 1'b0);
      `CHK("fetch top lower", {2'h0, 15'h7fff}, f_flash)
      `CHK("const top", {~b, 15'h7ffe}, c_flash)
      `CHK("const reserved", (~b) == 2'h3, c_rsv)
    end
    $display("t_map done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, exec_pc} = '0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge clk);
    t_reg();
    t_map();
    wrap_up();
  end
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
